//--- vlau_pkg.sv
// Package: constants and operation codes for the vector load and align unit
`default_nettype none
package vlau_pkg;
    localparam int ADDR_W    = 64;
    localparam int VEC_BYTES = 16;
    localparam int VEC_W     = 128;
    localparam int OFS_W     = 4;
    localparam logic [ADDR_W-1:0] VEC_ALIGN_MASK = 64'hffff_ffff_ffff_fff0;
    localparam logic [7:0] SHR_BASE = 8'h10;
    localparam logic [VEC_W-1:0] RESULT_RESET = 128'h0;
    typedef enum logic [2:0] {
        OP_LOAD_BYTE,
        OP_LOAD_HALF,
        OP_LOAD_WORD,
        OP_LOAD_VEC_LRU,
        OP_PERM_LEFT,
        OP_PERM_RIGHT
    } vop_e;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_MEM
    } vstate_e;
endpackage
`default_nettype wire

//--- perm_ctrl_gen.sv
// Permute control vector generator for shift-left and shift-right alignment
`default_nettype none
module perm_ctrl_gen
    import vlau_pkg::*;
(
    // Shift request
    input  wire logic [OFS_W-1:0] byte_shift_amount,
    input  wire logic             shift_right,
    // Control vector
    output logic [VEC_W-1:0]      perm_vec
);
    // Pure function of the four offset bits and shift_right, no memory access
    wire logic [7:0] start_byte = shift_right ? (SHR_BASE - {4'h0, byte_shift_amount})
                                              : {4'h0, byte_shift_amount};
    always_comb begin
        perm_vec = '0;
        for (int k = 0; k < VEC_BYTES; k++) begin
            // Byte k counted from the most significant end
            perm_vec[VEC_W-1-8*k -: 8] = start_byte + 8'(k);
        end
    end
endmodule
`default_nettype wire

//--- vector_load_align_unit.sv
// Vector load and alignment permute unit: element, full-vector and permute-control operations
`default_nettype none
module vector_load_align_unit
    import vlau_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Operation request
    input  wire logic              req_valid,
    input  wire logic [2:0]        req_op,
    input  wire logic [ADDR_W-1:0] req_base,
    input  wire logic [ADDR_W-1:0] req_index,
    output logic                   req_ready,
    // Memory side
    output logic                   mem_req,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_mark_lru,
    input  wire logic              mem_ack,
    input  wire logic [VEC_W-1:0]  mem_rdata,
    // Result
    output logic                   res_valid,
    output logic [VEC_W-1:0]       res_data,
    output logic [VEC_BYTES-1:0]   res_byte_valid
);
    function automatic logic [ADDR_W-1:0] align_down(input logic [ADDR_W-1:0] a, input logic [2:0] op);
        case (op)
            OP_LOAD_HALF:    align_down = {a[ADDR_W-1:1], 1'b0};
            OP_LOAD_WORD:    align_down = {a[ADDR_W-1:2], 2'b00};
            OP_LOAD_VEC_LRU: align_down = a & VEC_ALIGN_MASK;
            default:         align_down = a;
        endcase
    endfunction

    function automatic logic [VEC_BYTES-1:0] elem_mask(input logic [2:0] op, input logic [OFS_W-1:0] ofs);
        logic [VEC_BYTES-1:0] m;
        m = '0;
        case (op)
            OP_LOAD_BYTE:    m = 16'h8000 >> ofs;
            OP_LOAD_HALF:    m = 16'hc000 >> ofs;
            OP_LOAD_WORD:    m = 16'hf000 >> ofs;
            OP_LOAD_VEC_LRU: m = 16'hffff;
            default:         m = 16'hffff;
        endcase
        elem_mask = m;
    endfunction

    vstate_e              state_ff;
    vstate_e              nxt_state;
    logic                 req_ready_ff;
    logic                 mem_req_ff;
    logic [ADDR_W-1:0]    mem_addr_ff;
    logic                 mem_lru_ff;
    logic                 res_valid_ff;
    logic [VEC_W-1:0]     res_data_ff;
    logic [VEC_BYTES-1:0] res_mask_ff;
    logic [2:0]           op_ff;

    wire logic [ADDR_W-1:0] sum_addr          = req_base + req_index;
    wire logic [ADDR_W-1:0] effective_address = align_down(sum_addr, req_op);
    wire logic              is_perm  = (req_op == OP_PERM_LEFT) || (req_op == OP_PERM_RIGHT);
    wire logic              is_load  = (req_op <= OP_LOAD_VEC_LRU);
    wire logic              take     = req_valid && req_ready_ff;
    wire logic              ack_ok   = (state_ff == ST_WAIT_MEM) && mem_ack;
    wire logic [OFS_W-1:0]  line_ofs = mem_addr_ff[OFS_W-1:0];
    wire logic [VEC_W-1:0]  perm_vec;

    // Only the low four sum bits reach the generator
    perm_ctrl_gen u_perm (
        .byte_shift_amount (sum_addr[OFS_W-1:0]),
        .shift_right       (req_op == OP_PERM_RIGHT),
        .perm_vec          (perm_vec)
    );

    // Memory returns the aligned 16-byte line; the element already sits in byte slot ofs
    wire logic [VEC_BYTES-1:0] load_mask = elem_mask(op_ff, line_ofs);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:     if (take && is_load) nxt_state = ST_WAIT_MEM;
            ST_WAIT_MEM: if (mem_ack) nxt_state = ST_IDLE;
            default:     nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= ST_IDLE;
            req_ready_ff <= 1'b1;
            op_ff        <= 3'h0;
        end else begin
            state_ff     <= nxt_state;
            req_ready_ff <= (nxt_state == ST_IDLE);
            if (take) op_ff <= req_op;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_req_ff  <= 1'b0;
            mem_addr_ff <= '0;
            mem_lru_ff  <= 1'b0;
        end else if (take && is_load) begin
            mem_req_ff  <= 1'b1;
            mem_addr_ff <= effective_address;
            mem_lru_ff  <= (req_op == OP_LOAD_VEC_LRU);
        end else if (mem_ack) begin
            mem_req_ff  <= 1'b0;
            mem_lru_ff  <= 1'b0;
        end
    end

    // Undefined slots read as zero so the output never carries stale data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            res_valid_ff <= 1'b0;
            res_data_ff  <= RESULT_RESET;
            res_mask_ff  <= '0;
        end else begin
            res_valid_ff <= (take && is_perm) || ack_ok;
            if (take && is_perm) begin
                res_data_ff <= perm_vec;
                res_mask_ff <= '1;
            end else if (ack_ok) begin
                for (int k = 0; k < VEC_BYTES; k++) begin
                    res_data_ff[VEC_W-1-8*k -: 8] <= load_mask[VEC_BYTES-1-k] ? mem_rdata[VEC_W-1-8*k -: 8] : 8'h00;
                end
                res_mask_ff <= load_mask;
            end
        end
    end

    assign req_ready      = req_ready_ff;
    assign mem_req        = mem_req_ff;
    assign mem_addr       = mem_addr_ff;
    assign mem_mark_lru   = mem_lru_ff;
    assign res_valid      = res_valid_ff;
    assign res_data       = res_data_ff;
    assign res_byte_valid = res_mask_ff;

    // Alignment and marking are checked at the memory side while a request stands
    chk_word_align: assert property (@(posedge clk) disable iff (!reset_n)
        (mem_req && op_ff == OP_LOAD_WORD) |-> (mem_addr[1:0] == 2'b00))
        else $error("word load address is not word aligned");

    chk_half_align: assert property (@(posedge clk) disable iff (!reset_n)
        (mem_req && op_ff == OP_LOAD_HALF) |-> (mem_addr[0] == 1'b0))
        else $error("halfword load address is not halfword aligned");

    chk_line_align: assert property (@(posedge clk) disable iff (!reset_n)
        (mem_req && mem_mark_lru) |-> (mem_addr[OFS_W-1:0] == 4'h0))
        else $error("vector load address is not line aligned");

    chk_lru_only: assert property (@(posedge clk) disable iff (!reset_n)
        mem_mark_lru |-> (mem_req && op_ff == OP_LOAD_VEC_LRU))
        else $error("replacement hint raised outside a vector load");

    chk_lru_with_vec: assert property (@(posedge clk) disable iff (!reset_n)
        (take && req_op == OP_LOAD_VEC_LRU) |=> (mem_req && mem_mark_lru))
        else $error("vector load issued without the replacement hint");

    chk_perm_no_mem: assert property (@(posedge clk) disable iff (!reset_n)
        (take && is_perm) |=> (!mem_req && $stable(mem_addr)))
        else $error("permute control touched the memory side");

    chk_perm_full: assert property (@(posedge clk) disable iff (!reset_n)
        (take && is_perm) |=> (res_valid && res_byte_valid == 16'hffff))
        else $error("permute control not returned as a full vector");

    // Only the end bytes are checked here; the ramp between them is left to the bench
    chk_shl_bytes: assert property (@(posedge clk) disable iff (!reset_n)
        (take && req_op == OP_PERM_LEFT) |=>
            (res_data[VEC_W-1 -: 8] == {4'h0, $past(sum_addr[OFS_W-1:0])}
             && res_data[7:0] == {4'h0, $past(sum_addr[OFS_W-1:0])} + 8'h0f))
        else $error("shift-left control end bytes wrong");

    chk_shr_bytes: assert property (@(posedge clk) disable iff (!reset_n)
        (take && req_op == OP_PERM_RIGHT) |=>
            (res_data[VEC_W-1 -: 8] == SHR_BASE - {4'h0, $past(sum_addr[OFS_W-1:0])}
             && res_data[7:0] == SHR_BASE + 8'h0f - {4'h0, $past(sum_addr[OFS_W-1:0])}))
        else $error("shift-right control end bytes wrong");

    // Slot checks lean on mem_addr, which keeps the element-aligned load address until the next load
    chk_byte_slot: assert property (@(posedge clk) disable iff (!reset_n)
        (res_valid && op_ff == OP_LOAD_BYTE) |->
            ($countones(res_byte_valid) == 1 && res_byte_valid[4'hf - mem_addr[OFS_W-1:0]]))
        else $error("byte element in the wrong slot");

    chk_half_slot: assert property (@(posedge clk) disable iff (!reset_n)
        (res_valid && op_ff == OP_LOAD_HALF) |->
            ($countones(res_byte_valid) == 2 && res_byte_valid[4'hf - mem_addr[OFS_W-1:0]]))
        else $error("halfword element in the wrong slot");

    chk_word_slot: assert property (@(posedge clk) disable iff (!reset_n)
        (res_valid && op_ff == OP_LOAD_WORD) |->
            ($countones(res_byte_valid) == 4 && res_byte_valid[4'hf - mem_addr[OFS_W-1:0]]))
        else $error("word element in the wrong slot");

    chk_line_mask: assert property (@(posedge clk) disable iff (!reset_n)
        (res_valid && op_ff == OP_LOAD_VEC_LRU) |-> (res_byte_valid == 16'hffff))
        else $error("vector load did not return all sixteen bytes");

    chk_load_result: assert property (@(posedge clk) disable iff (!reset_n)
        ack_ok |=> res_valid)
        else $error("memory answer not turned into a result");

    // Scenario coverage
    cov_perm_left: cover property (@(posedge clk) disable iff (!reset_n)
        take && req_op == OP_PERM_LEFT);

    cov_perm_right: cover property (@(posedge clk) disable iff (!reset_n)
        take && req_op == OP_PERM_RIGHT);

    cov_elem_load: cover property (@(posedge clk) disable iff (!reset_n)
        ack_ok && op_ff != OP_LOAD_VEC_LRU);

    cov_lru_load: cover property (@(posedge clk) disable iff (!reset_n)
        ack_ok && op_ff == OP_LOAD_VEC_LRU);
endmodule
`default_nettype wire

//--- mem_model.sv
// Memory model: returns a 16-byte line after a chosen delay
`default_nettype none
module mem_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Request and delay
    input  wire logic        mem_req,
    input  wire logic [63:0] mem_addr,
    input  wire logic [3:0]  ack_delay,
    // Answer
    output logic             mem_ack,
    output logic [127:0]     mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff <= 4'h0;
            mem_ack <= 1'h0;
            mem_rdata <= 128'h0;
        end else if (mem_req && !mem_ack && wait_ff >= ack_delay) begin
            mem_ack <= 1'h1;
            for (int k = 0; k < 16; k++) mem_rdata[127-8*k -: 8] <= {mem_addr[7:4], 4'(k)};
        end else begin
            mem_ack <= 1'h0;
            wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
            // Inverted each cycle outside the ack, so stale data matches the last line again every second cycle
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

//--- vector_load_align_unit_test.sv
// Self-checking bench for the vector load and align unit
`default_nettype none
module vector_load_align_unit_test import vlau_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 0, reset_n = 0, req_valid = 0, req_ready, mem_req, mem_mark_lru, mem_ack, res_valid;
    logic [2:0]   req_op = 0;
    logic [3:0]   ack_delay = 0;
    logic [15:0]  res_byte_valid;
    logic [63:0]  req_base = 0, req_index = 0, mem_addr;
    logic [127:0] mem_rdata, res_data;
    int           err_total = 0, checked = 0, cycles = 0;
    vector_load_align_unit i_dut (.clk, .reset_n, .req_valid, .req_op, .req_base, .req_index, .req_ready,
        .mem_req, .mem_addr, .mem_mark_lru, .mem_ack, .mem_rdata, .res_valid, .res_data, .res_byte_valid);
    mem_model i_mem (.clk, .reset_n, .mem_req, .mem_addr, .ack_delay, .mem_ack, .mem_rdata);
    initial forever #4 clk = ~clk;
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // Base and index carry into each other so the sum itself is exercised
    task automatic run_op(input logic [2:0] op, input logic [63:0] sum, input logic ld, input logic [127:0] d,
                          input logic [15:0] bv);
        int n;
        logic got, lru;
        logic [63:0] adr;
        logic [63:0] exp_adr;
        got = 0;
        lru = 0;
        adr = 0;
        @(negedge clk);
        req_op = op;
        req_base = sum - 64'h1b;
        req_index = 64'h1b;
        req_valid = 1'h1;
        for (n = 0; n < 20 && req_ready !== 1'h1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'h0;
        for (n = 0; n < 40 && res_valid !== 1'h1; n++) begin
            if (mem_req === 1'h1) begin
                got = 1'h1;
                adr = mem_addr;
                lru = mem_mark_lru;
            end
            @(negedge clk);
        end
        check(128'(res_valid), 128'h1);
        check(128'(got), 128'(ld));
        check(res_data, d);
        if (ld) begin
            check(128'(res_byte_valid), 128'(bv));
            exp_adr = (op == 3'h3) ? (sum & VEC_ALIGN_MASK) : (sum & ~((64'h1 << op) - 64'h1));
            check(128'(adr), 128'(exp_adr));
            check(128'(lru), 128'(op == 3'h3));
        end
        if (op == 3'h3) check(128'(adr), 128'(sum & VEC_ALIGN_MASK));
    endtask
    task automatic t_perm();
        logic [127:0] d;
        for (int r = 0; r < 2; r++) begin
            for (int sh = 0; sh < 16; sh++) begin
                for (int b = 0; b < 16; b++) d[127-8*b -: 8] = 8'(r ? 16 - sh + b : sh + b);
                run_op(3'(4 + r), {60'h0f0f_0f0f_0f0f_0f0, 4'(sh)}, 1'h0, d, 16'h0);
            end
        end
        $display("Permute test done");
    endtask
    task automatic t_element();
        logic [127:0] d;
        logic [63:0] sum;
        logic [15:0] bv;
        logic [3:0] off;
        for (int op = 0; op < 3; op++) begin
            for (int a = 0; a < 16; a += 5) begin
                sum = 64'h7700_0000_0000_1230 + 64'(a);
                off = sum[3:0] & 4'(~((1 << op) - 1));
                d = 0;
                bv = 0;
                ack_delay = 4'(a);
                for (int b = 0; b < 16; b++) begin
                    if (b >= off && b < off + (1 << op)) begin
                        d[127-8*b -: 8] = {sum[7:4], 4'(b)};
                        bv[15-b] = 1'h1;
                    end
                end
                run_op(3'(op), sum, 1'h1, d, bv);
            end
        end
        $display("Element load test done");
    endtask
    task automatic t_vector();
        logic [127:0] d;
        for (int b = 0; b < 16; b++) d[127-8*b -: 8] = {4'ha, 4'(b)};
        ack_delay = 4'h6;
        run_op(3'h3, 64'hdead_beef_0000_04a7, 1'h1, d, 16'hffff);
        ack_delay = 4'h0;
        run_op(3'h3, 64'h1234_0000_0000_ffaf, 1'h1, d, 16'hffff);
        $display("Vector load test done");
    endtask
    // A load still waiting on memory is cut by reset; the unit must come back idle and usable
    task automatic t_reset();
        logic [127:0] d;
        for (int b = 0; b < 16; b++) d[127-8*b -: 8] = {4'h5, 4'(b)};
        ack_delay = 4'hf;
        @(negedge clk);
        req_op = 3'h3;
        req_base = 64'h0;
        req_index = 64'h0000_0000_0000_0150;
        req_valid = 1'h1;
        @(negedge clk);
        req_valid = 1'h0;
        check(128'(mem_req), 128'h1);
        reset_n = 1'h0;
        @(negedge clk);
        check(128'({req_ready, mem_req, mem_mark_lru, res_valid, res_byte_valid}), 128'h8_0000);
        check(res_data | 128'(mem_addr), 128'h0);
        repeat (2) @(negedge clk);
        reset_n = 1'h1;
        ack_delay = 4'h0;
        run_op(3'h3, 64'h0000_0000_0000_0158, 1'h1, d, 16'hffff);
        $display("Reset test done");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'h1;
        t_perm();
        t_element();
        t_vector();
        t_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
